/* shared/sdasp_pkg.sv */
// Package for the sigma-delta converter serial port: constants, types and the operation summary
// Operation
// [R1] Input shift register bits move to setup, clock or comms register per select field.
// [R2] Low reset returns all control, interface, calibration and filter state to power-on.
// [R3] Select input is active low; serial traffic is ignored while it is high.
// [R4] With select tied low the port works as a three-wire interface.
// [R5] Select may pick one device on a shared bus or frame each transfer.
// [R6] Host supplies the serial clock; the device never drives it.
// [R7] Continuous or bursty serial clock are both accepted.
// [R8] Word-ready goes low when a new conversion word sits in the data register.
// [R9] Word-ready goes high after the host has read a full output word.
// [R10] Unread word: word-ready high for 500 master clocks before the next update.
// [R11] Host must not start a data read while word-ready is high.
// [R12] Word-ready goes low again once the data register update is done.
// [R13] Word-ready also signals completion of on-chip calibration.
// [R14] Output shift register loads from setup, comms, clock or data register per select field.
// [R15] Host starts each access with a comms write choosing register and direction.
package sdasp_pkg;
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned RDY_HIGH_MCLK = 500;
  localparam logic [9:0] RDY_HIGH_CYC = 10'(RDY_HIGH_MCLK);
  localparam logic [7:0] COMMS_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h01;
  localparam logic [7:0] CLKREG_RST = 8'h05;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam int unsigned RS_LSB = 4;
  localparam int unsigned RW_BIT = 3;
  localparam logic [2:0] RS_COMMS = 3'h0;
  localparam logic [2:0] RS_SETUP = 3'h1;
  localparam logic [2:0] RS_CLOCK = 3'h2;
  localparam logic [2:0] RS_DATA = 3'h3;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;

  typedef enum logic [1:0] {
    SDASP_IDLE = 2'b00,
    SDASP_WRITE = 2'b01,
    SDASP_READ = 2'b10
  } sdasp_state_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] din_sync;
    logic sclk_prev;
  } sdasp_sync_t;

  typedef struct packed {
    sdasp_sync_t sync;
    sdasp_state_t state;
    logic [7:0] comms;
    logic [7:0] setup;
    logic [7:0] clkreg;
    logic [15:0] data;
    logic [15:0] in_sr;
    logic [15:0] out_sr;
    logic [4:0] bit_cnt;
    logic [4:0] bit_len;
    logic is_data_rd;
    logic ready_n;
    logic [9:0] hold_cnt;
    logic pend;
    logic [15:0] pend_word;
    logic dout;
    logic cal_busy;
  } sdasp_state_all_t;
endpackage : sdasp_pkg

/* core/sdasp_top.sv */
// Serial port of the sigma-delta converter with word-ready flag
`timescale 1ns/10ps
module sdasp_top (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic din_in,
  input wire logic conv_valid_in,
  input wire logic [15:0] conv_word_in,
  input wire logic cal_done_in,
  output logic dout_out,
  output logic word_ready_n_out,
  output logic [7:0] setup_out,
  output logic [7:0] clock_reg_out,
  output logic cal_start_out
);
  sdasp_pkg::sdasp_state_all_t r_ff, nxt_r;
  logic sclk_rise, sclk_fall, sel_act;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sync.sclk_sync = {r_ff.sync.sclk_sync[0], sclk_in};
    nxt_r.sync.cs_sync = {r_ff.sync.cs_sync[0], sel_n_in};
    nxt_r.sync.din_sync = {r_ff.sync.din_sync[0], din_in};
    nxt_r.sync.sclk_prev = r_ff.sync.sclk_sync[1];
    sclk_rise = r_ff.sync.sclk_sync[1] & ~r_ff.sync.sclk_prev;
    sclk_fall = ~r_ff.sync.sclk_sync[1] & r_ff.sync.sclk_prev;
    // Only edges matter, so gaps between clock bursts are harmless
    sel_act = ~r_ff.sync.cs_sync[1]; // see [R3] see [R4] see [R5] see [R7]

    // Select high aborts a frame, letting select act as frame sync
    if (!sel_act) begin
      nxt_r.state = sdasp_pkg::SDASP_IDLE; // see [R5]
      nxt_r.bit_cnt = 5'h00;
      // A cut data read must not stretch the next comms byte to 16 bits
      nxt_r.bit_len = sdasp_pkg::BYTE_BITS;
      // Idle line high, no stale bit left on a shared bus
      nxt_r.dout = 1'b1; // see [R3]
    end else begin
      if (sclk_fall) begin
        nxt_r.dout = r_ff.out_sr[15];
        if (r_ff.state == sdasp_pkg::SDASP_READ) begin
          nxt_r.out_sr = {r_ff.out_sr[14:0], 1'b0};
        end
      end
      if (sclk_rise) begin
        nxt_r.in_sr = {r_ff.in_sr[14:0], r_ff.sync.din_sync[1]};
        nxt_r.bit_cnt = r_ff.bit_cnt + 5'h01;
        if (r_ff.bit_cnt + 5'h01 == r_ff.bit_len) begin
          nxt_r.bit_cnt = 5'h00;
          case (r_ff.state)
            sdasp_pkg::SDASP_IDLE: begin
              nxt_r.comms = {r_ff.in_sr[6:0], r_ff.sync.din_sync[1]}; // see [R1] see [R15]
              if (r_ff.in_sr[sdasp_pkg::RW_BIT - 1]) begin
                nxt_r.state = sdasp_pkg::SDASP_READ;
                case (r_ff.in_sr[sdasp_pkg::RS_LSB + 1:sdasp_pkg::RS_LSB - 1]) // see [R14]
                  sdasp_pkg::RS_SETUP: nxt_r.out_sr = {r_ff.setup, 8'h00};
                  sdasp_pkg::RS_CLOCK: nxt_r.out_sr = {r_ff.clkreg, 8'h00};
                  sdasp_pkg::RS_DATA: nxt_r.out_sr = r_ff.data;
                  default: nxt_r.out_sr = {r_ff.comms, 8'h00};
                endcase
                nxt_r.is_data_rd = (r_ff.in_sr[sdasp_pkg::RS_LSB + 1:sdasp_pkg::RS_LSB - 1] == sdasp_pkg::RS_DATA);
                nxt_r.bit_len = nxt_r.is_data_rd ? sdasp_pkg::WORD_BITS : sdasp_pkg::BYTE_BITS;
              end else if (r_ff.in_sr[sdasp_pkg::RS_LSB + 1:sdasp_pkg::RS_LSB - 1] == sdasp_pkg::RS_SETUP ||
                           r_ff.in_sr[sdasp_pkg::RS_LSB + 1:sdasp_pkg::RS_LSB - 1] == sdasp_pkg::RS_CLOCK) begin
                // Data and comms writes stay comms-only updates
                nxt_r.state = sdasp_pkg::SDASP_WRITE;
                nxt_r.bit_len = sdasp_pkg::BYTE_BITS;
              end
            end
            sdasp_pkg::SDASP_WRITE: begin
              case (r_ff.comms[sdasp_pkg::RS_LSB +: 3]) // see [R1]
                sdasp_pkg::RS_SETUP: begin
                  nxt_r.setup = {r_ff.in_sr[6:0], r_ff.sync.din_sync[1]};
                  nxt_r.cal_busy = 1'b1; // Setup write starts a calibration
                  nxt_r.ready_n = 1'b1;
                end
                sdasp_pkg::RS_CLOCK: nxt_r.clkreg = {r_ff.in_sr[6:0], r_ff.sync.din_sync[1]};
                default: nxt_r.comms = {r_ff.in_sr[6:0], r_ff.sync.din_sync[1]};
              endcase
              nxt_r.state = sdasp_pkg::SDASP_IDLE;
            end
            default: begin
              if (r_ff.is_data_rd) begin
                nxt_r.ready_n = 1'b1; // see [R9]
              end
              nxt_r.state = sdasp_pkg::SDASP_IDLE;
              nxt_r.bit_len = sdasp_pkg::BYTE_BITS;
            end
          endcase
        end
      end
    end

    if (r_ff.cal_busy && cal_done_in) begin
      nxt_r.cal_busy = 1'b0;
      nxt_r.ready_n = 1'b0; // see [R13]
    end

    // New word: if unread, raise ready for the hold time before updating
    if (conv_valid_in && !r_ff.pend && !r_ff.cal_busy) begin
      nxt_r.pend = 1'b1;
      nxt_r.pend_word = conv_word_in;
      // The cycle that finds hold_cnt at zero is the last of the high time
      nxt_r.hold_cnt = r_ff.ready_n ? 10'h000 : sdasp_pkg::RDY_HIGH_CYC - 10'h001; // see [R10]
      nxt_r.ready_n = 1'b1;
    end
    if (r_ff.pend) begin
      if (r_ff.hold_cnt != 10'h000) begin
        nxt_r.hold_cnt = r_ff.hold_cnt - 10'h001;
        nxt_r.ready_n = 1'b1; // see [R10] see [R11]
      end else if (!nxt_r.cal_busy && !(r_ff.state == sdasp_pkg::SDASP_READ && r_ff.is_data_rd)) begin
        // Calibration owns the flag until it is done
        // A data read in progress delays the update rather than corrupting it
        nxt_r.data = r_ff.pend_word;
        nxt_r.pend = 1'b0;
        nxt_r.ready_n = 1'b0; // see [R8] see [R12]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_ff <= '{sync: '{sclk_sync: 2'h3, cs_sync: 2'h3, din_sync: 2'h0, sclk_prev: 1'b1},
                state: sdasp_pkg::SDASP_IDLE, comms: sdasp_pkg::COMMS_RST, setup: sdasp_pkg::SETUP_RST,
                clkreg: sdasp_pkg::CLKREG_RST, data: sdasp_pkg::DATA_RST, in_sr: 16'h0000,
                out_sr: 16'h0000, bit_cnt: 5'h00, bit_len: sdasp_pkg::BYTE_BITS, is_data_rd: 1'b0,
                ready_n: 1'b1, hold_cnt: 10'h000, pend: 1'b0, pend_word: 16'h0000, dout: 1'b1,
                cal_busy: 1'b0}; // see [R2]
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from flops; serial clock is only ever an input
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_out <= 1'b1;
      word_ready_n_out <= 1'b1;
      setup_out <= sdasp_pkg::SETUP_RST;
      clock_reg_out <= sdasp_pkg::CLKREG_RST;
      cal_start_out <= 1'b0;
    end else begin
      dout_out <= nxt_r.dout; // see [R6]
      word_ready_n_out <= nxt_r.ready_n;
      setup_out <= nxt_r.setup;
      clock_reg_out <= nxt_r.clkreg;
      cal_start_out <= nxt_r.cal_busy & ~r_ff.cal_busy;
    end
  end
endmodule : sdasp_top

/* tb/sdasp_top_asserts.sv */
// Checker for the converter serial port
`timescale 1ns/10ps
module sdasp_top_asserts (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sel_n_in,
  input wire logic conv_valid_in,
  input wire logic cal_done_in,
  input wire logic dout_out,
  input wire logic word_ready_n_out,
  input wire logic [7:0] setup_out,
  input wire logic [7:0] clock_reg_out,
  input wire logic cal_start_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_vals: assert property ($rose(rst_n_in) |-> word_ready_n_out && dout_out && !cal_start_out
    && setup_out == sdasp_pkg::SETUP_RST && clock_reg_out == sdasp_pkg::CLKREG_RST) else $error("reset values");
  a_cal_pulse: assert property (cal_start_out |=> !cal_start_out) else $error("cal pulse");
  a_cal_busy: assert property (cal_start_out && !cal_done_in |=> word_ready_n_out) else $error("cal ready");
  // Select held idle so no read can delay the update
  a_conv_rise: assert property (sel_n_in [*4] ##0 (conv_valid_in && !word_ready_n_out) |=> ##[0:2] word_ready_n_out)
    else $error("no ready rise");
  a_setup_cal: assert property ($changed(setup_out) |-> $past(cal_start_out) or ##[0:2] cal_start_out)
    else $error("setup no cal");
  a_idle_setup: assert property (sel_n_in [*6] |-> $stable(setup_out)) else $error("setup moved");
  a_idle_clock: assert property (sel_n_in [*6] |-> $stable(clock_reg_out)) else $error("clock moved");
  a_idle_dout: assert property (sel_n_in [*6] |-> dout_out) else $error("dout busy");
endmodule : sdasp_top_asserts

/* tb/sdasp_host.sv */
// Host serial master model
`timescale 1ns/10ps
module sdasp_host (
  input wire logic dout_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1; // Host owns the clock, idle high
    sel_n_out = 1'b1;
    din_out = 1'b0;
  end
  // Comms byte always leads the frame
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n, input bit burst,
    input bit keep, output logic [15:0] rd, input bit unsel = 1'b0);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    #37 sel_n_out = unsel;
    for (int i = 0; i < 8 + n; i++) begin
      if (burst && i == 8) #900;
      sclk_out = 1'b0;
      din_out = sh[23];
      #80 sclk_out = 1'b1;
      rd = {rd[14:0], dout_in};
      sh = sh << 1;
      #80;
    end
    din_out = ~din_out; // No stale value after release
    #300 if (!keep) sel_n_out = 1'b1;
  endtask : xfer
endmodule : sdasp_host

/* tb/sdasp_top_test.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t got %h", $time, a); end end
module sdasp_top_test;
  logic clock_in, rst_n_in, sclk, sel_n, din, conv_v, cal_done, dout, rdy_n, cal_start;
  logic [15:0] conv_w, rd;
  logic [7:0] setup, clk_reg;
  int error_cnt, n_checks, cnt;
  logic [15:0] rows [4] = '{16'h1044, 16'h200c, 16'h1844, 16'h280c};
  sdasp_top DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sel_n_in(sel_n), .din_in(din),
    .conv_valid_in(conv_v), .conv_word_in(conv_w), .cal_done_in(cal_done), .dout_out(dout),
    .word_ready_n_out(rdy_n), .setup_out(setup), .clock_reg_out(clk_reg), .cal_start_out(cal_start));
  sdasp_host host (.dout_in(dout), .sclk_out(sclk), .sel_n_out(sel_n), .din_out(din));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic wait_rdy(input logic lvl);
    cnt = 0;
    while (rdy_n !== lvl && cnt < 2000) begin
      @(posedge clock_in);
      cnt++;
    end
    if (cnt == 2000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      results();
    end
  endtask : wait_rdy
  task automatic conv(input logic [15:0] w);
    @(posedge clock_in);
    conv_v <= 1'b1;
    conv_w <= w;
    @(posedge clock_in);
    conv_v <= 1'b0;
  endtask : conv
  initial begin
    rst_n_in = 1'b0;
    conv_v = 1'b0;
    conv_w = 16'h0000;
    cal_done = 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK({rdy_n, dout, setup, clk_reg}, {2'b11, sdasp_pkg::SETUP_RST, sdasp_pkg::CLKREG_RST})
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    foreach (rows[i]) begin
      host.xfer(rows[i][15:8], {rows[i][7:0], 8'h00}, 8, 1'b0, 1'b0, rd);
      if (rows[i][11]) `CHK(rd[7:0], rows[i][7:0])
      else `CHK(rows[i][12] ? setup : clk_reg, rows[i][7:0])
    end
    // Clocked traffic with select high must not reach any register
    host.xfer(8'h10, 16'h9900, 8, 1'b0, 1'b0, rd, 1'b1);
    `CHK(setup, 8'h44)
    `CHK(rdy_n, 1'b1)
    @(posedge clock_in);
    cal_done <= 1'b1;
    @(posedge clock_in);
    cal_done <= 1'b0;
    wait_rdy(1'b0);
    conv(16'ha5c3);
    wait_rdy(1'b1);
    cnt = 0;
    while (rdy_n === 1'b1 && cnt < 600) begin
      @(posedge clock_in);
      cnt++;
    end
    `CHK(cnt, 500)
    host.xfer(8'h38, 16'h0000, 16, 1'b1, 1'b0, rd);
    `CHK(rd, 16'ha5c3)
    `CHK(rdy_n, 1'b1)
    wait_rdy(1'b1);
    conv(16'h5a3c);
    repeat (3) @(posedge clock_in);
    `CHK(rdy_n, 1'b0)
    host.xfer(8'h38, 16'h0000, 16, 1'b0, 1'b0, rd);
    `CHK(rd, 16'h5a3c)
    host.xfer(8'h20, 16'h3300, 8, 1'b0, 1'b1, rd);
    host.xfer(8'h28, 16'h0000, 8, 1'b0, 1'b1, rd);
    `CHK(rd[7:0], 8'h33)
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    `CHK({rdy_n, setup, clk_reg}, {1'b1, sdasp_pkg::SETUP_RST, sdasp_pkg::CLKREG_RST})
    results();
  end
endmodule : sdasp_top_test
bind sdasp_top sdasp_top_asserts u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .sel_n_in(sel_n_in),
  .conv_valid_in(conv_valid_in), .cal_done_in(cal_done_in), .dout_out(dout_out), .word_ready_n_out(word_ready_n_out),
  .setup_out(setup_out), .clock_reg_out(clock_reg_out), .cal_start_out(cal_start_out));
